// ---- ips_regs.sv ----
`timescale 1ns/1ps
module ips_regs (
  input  wire  logic              ref_clk,
  input  wire  logic              rst,
  // request lines from the maskable sources
  input  wire  ips_pkg::ips_src_t src_req,
  // avalon-mm slave
  input  wire  logic [15:0]       avs_address,
  input  wire  logic              avs_read,
  input  wire  logic              avs_write,
  input  wire  logic [3:0]        avs_byteenable,
  input  wire  logic [31:0]       avs_writedata,
  output logic       [31:0]       avs_readdata,
  output logic                    avs_waitrequest,
  // level interrupt, unmasked sticky events
  output logic                    irq
);
  import ips_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [NUM_SRC-1:0]    src_sync;          // synchronised request lines
  logic [NUM_SRC-1:0]    src_prev_ff;       // previous sample, for edges
  logic [NUM_SRC-1:0]    nxt_src_prev;
  logic [LOW_WIDTH-1:0]  low_pending_flag_group_ff;
  logic [MID_WIDTH-1:0]  mid_pending_flag_group_ff;
  logic [HIGH_WIDTH-1:0] high_pending_flag_group_ff;
  logic [LOW_WIDTH-1:0]  nxt_low;
  logic [MID_WIDTH-1:0]  nxt_mid;
  logic [HIGH_WIDTH-1:0] nxt_high;
  logic [NUM_SRC-1:0]    irq_status_ff;     // sticky rising-edge events
  logic [NUM_SRC-1:0]    irq_mask_ff;       // one enables an event
  logic [NUM_SRC-1:0]    nxt_status;
  logic [NUM_SRC-1:0]    nxt_mask;
  logic                  irq_ff;
  logic                  nxt_irq;
  logic [31:0]           rdata_ff;
  logic [31:0]           nxt_rdata;
  logic                  ack_ff;            // answer phase marker
  logic                  nxt_ack;
  logic                  wait_ff;           // registered waitrequest
  logic                  nxt_wait;
  ips_req_t              req;
  logic [NUM_SRC-1:0]    rise;
  logic [NUM_SRC-1:0]    wr_bits;

  // bundle the bus request
  assign req = '{address: avs_address, read: avs_read, write: avs_write,
                 byteenable: avs_byteenable, writedata: avs_writedata};

  // ----------------------------------------------------------------
  // input synchroniser: sources may sit on other clocks
  // ----------------------------------------------------------------
  ips_sync u_sync (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .async_src (src_req),
    .sync_src  (src_sync)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte-enabled lanes of a 16-bit field, used for status clears
  function automatic logic [15:0] lane_bits(input logic [3:0]  be,
                                            input logic [31:0] wd);
    lane_bits = {wd[15:8] & {8{be[1]}}, wd[7:0] & {8{be[0]}}};
  endfunction : lane_bits

  // address hit test, shared by read and write decode
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ----------------------------------------------------------------
  // pending flag mirror
  // ----------------------------------------------------------------
  // flags follow the request level with two sync plus one register
  // stage; reset and the software interrupt have no line here at all
  always_comb begin
    nxt_low  = src_sync[LOW_WIDTH-1:0];
    nxt_mid  = src_sync[LOW_WIDTH+MID_WIDTH-1:LOW_WIDTH];
    nxt_high = src_sync[NUM_SRC-1:LOW_WIDTH+MID_WIDTH];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      low_pending_flag_group_ff  <= PENDING_RESET[LOW_WIDTH-1:0];
      mid_pending_flag_group_ff  <= PENDING_RESET[MID_WIDTH-1:0];
      high_pending_flag_group_ff <= PENDING_RESET[HIGH_WIDTH-1:0];
    end else begin
      low_pending_flag_group_ff  <= nxt_low;
      mid_pending_flag_group_ff  <= nxt_mid;
      high_pending_flag_group_ff <= nxt_high;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  // a request edge sets its status bit; write-one clears, but a set in
  // the same cycle wins so no event is lost
  always_comb begin
    rise         = src_sync & ~src_prev_ff;
    nxt_src_prev = src_sync;
    wr_bits      = lane_bits(req.byteenable, req.writedata);
    nxt_status   = irq_status_ff;
    nxt_mask     = irq_mask_ff;
    if (req.write && !ack_ff) begin
      if (hit(req.address, IRQ_STATUS_OFS)) begin
        nxt_status = irq_status_ff & ~wr_bits;   // write one to clear
      end
      if (hit(req.address, IRQ_MASK_OFS)) begin
        nxt_mask = {req.byteenable[1] ? req.writedata[15:8] : irq_mask_ff[15:8],
                    req.byteenable[0] ? req.writedata[7:0]  : irq_mask_ff[7:0]};
      end
    end
    nxt_status = nxt_status | rise;              // set beats clear
    nxt_irq    = |(nxt_status & nxt_mask);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      src_prev_ff   <= SRC_RESET;
      irq_status_ff <= SRC_RESET;
      irq_mask_ff   <= SRC_RESET;
      irq_ff        <= 1'b0;
    end else begin
      src_prev_ff   <= nxt_src_prev;
      irq_status_ff <= nxt_status;
      irq_mask_ff   <= nxt_mask;
      irq_ff        <= nxt_irq;
    end
  end

  // ----------------------------------------------------------------
  // avalon-mm slave
  // ----------------------------------------------------------------
  // one wait state: the request is seen, data is registered, then
  // waitrequest drops for one cycle; writes to pending registers
  // are accepted and discarded
  always_comb begin
    nxt_ack   = 1'b0;
    nxt_rdata = rdata_ff;
    if ((req.read || req.write) && !ack_ff) begin
      nxt_ack = 1'b1;
    end
    nxt_wait  = ~nxt_ack;                        // low only in the answer cycle
    if (req.read && !ack_ff) begin
      nxt_rdata = RDATA_RESET;                   // unmapped reads as zero
      if (hit(req.address, PENDING_FLAGS_LOW_OFS)) begin
        nxt_rdata[7:0] = {low_pending_flag_group_ff,
                          {LOW_SHIFT{1'b0}}};
      end else if (hit(req.address, PENDING_FLAGS_MID_OFS)) begin
        nxt_rdata[7:0] = mid_pending_flag_group_ff;
      end else if (hit(req.address, PENDING_FLAGS_HIGH_OFS)) begin
        nxt_rdata[7:0] = {6'h00, high_pending_flag_group_ff};
      end else if (hit(req.address, IRQ_STATUS_OFS)) begin
        nxt_rdata[15:0] = irq_status_ff;
      end else if (hit(req.address, IRQ_MASK_OFS)) begin
        nxt_rdata[15:0] = irq_mask_ff;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_ff   <= 1'b0;
      wait_ff  <= 1'b1;
      rdata_ff <= RDATA_RESET;
    end else begin
      ack_ff   <= nxt_ack;
      wait_ff  <= nxt_wait;
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // waitrequest comes from its own flop; high whenever no answer
  // is being given, including idle and reset
  assign avs_waitrequest = wait_ff;
  assign avs_readdata    = rdata_ff;
  assign irq             = irq_ff;

endmodule : ips_regs

// ---- ips_pkg.sv ----
package ips_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses; flag groups on consecutive bytes, status and mask on aligned words)
  // ----------------------------------------------------------------
  localparam logic [15:0] PENDING_FLAGS_LOW_OFS  = 16'hFE04;  // low group
  localparam logic [15:0] PENDING_FLAGS_MID_OFS  = 16'hFE05;  // mid group
  localparam logic [15:0] PENDING_FLAGS_HIGH_OFS = 16'hFE06;  // high group
  localparam logic [15:0] IRQ_STATUS_OFS         = 16'hFE08;  // sticky events
  localparam logic [15:0] IRQ_MASK_OFS           = 16'hFE0C;  // event mask

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  PENDING_RESET = 8'h00;  // all pending flags clear
  localparam logic [15:0] SRC_RESET     = 16'h0000;  // sampled sources clear
  localparam logic [31:0] RDATA_RESET   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // field positions and widths
  // ----------------------------------------------------------------
  localparam int NUM_SRC      = 16;  // maskable request lines
  localparam int LOW_SHIFT    = 2;   // low group sits in bits 7..2
  localparam int LOW_WIDTH    = 6;
  localparam int MID_WIDTH    = 8;
  localparam int HIGH_WIDTH   = 2;   // high group sits in bits 1..0
  localparam int ADDR_WIDTH   = 16;

  // ----------------------------------------------------------------
  // source request lines, one bit per maskable source
  // ----------------------------------------------------------------
  typedef struct packed {
    logic periodic_timebase;      // high bit 1
    logic converter_complete;     // high bit 0
    logic keyboard;               // mid bit 7
    logic serial_transmit;        // mid bit 6
    logic serial_receive;         // mid bit 5
    logic serial_error;           // mid bit 4
    logic sync_transmit;          // mid bit 3
    logic sync_receive;           // mid bit 2
    logic timer_two_overflow;     // mid bit 1
    logic timer_two_ch1;          // mid bit 0
    logic timer_two_ch0;          // low bit 7
    logic timer_one_overflow;     // low bit 6
    logic timer_one_ch1;          // low bit 5
    logic timer_one_ch0;          // low bit 4
    logic clock_generator_lock;   // low bit 3
    logic external_request;       // low bit 2
  } ips_src_t;

  // ----------------------------------------------------------------
  // bus request bundle
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_WIDTH-1:0] address;
    logic                  read;
    logic                  write;
    logic [3:0]            byteenable;
    logic [31:0]           writedata;
  } ips_req_t;

endpackage : ips_pkg

// ---- ips_sync.sv ----
`timescale 1ns/1ps
// two-stage synchroniser bank for the request lines
module ips_sync (
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire ips_pkg::ips_src_t           async_src,
  output logic      [ips_pkg::NUM_SRC-1:0] sync_src
);
  import ips_pkg::*;

  logic [NUM_SRC-1:0] meta_ff;      // first stage, read only by stage two
  logic [NUM_SRC-1:0] sync_ff;      // second stage
  logic [NUM_SRC-1:0] nxt_meta;
  logic [NUM_SRC-1:0] nxt_sync;

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  always_comb begin
    nxt_meta = async_src;
    nxt_sync = meta_ff;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_ff <= SRC_RESET;
      sync_ff <= SRC_RESET;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_src = sync_ff;

endmodule : ips_sync

// ---- ips_src_model.sv ----
`timescale 1ns/1ps
// far-side request lines: each source holds its level until told otherwise
module ips_src_model (
  input  wire ips_pkg::ips_src_t want_req,
  input  wire logic              ref_clk,
  input  wire logic              rst,
  output ips_pkg::ips_src_t      src_req
);
  import ips_pkg::*;
  ips_src_t req_ff;   // registered request levels
  ips_src_t nxt_req;
  // peripherals drop every request while the system is in reset
  always_comb nxt_req = rst ? ips_src_t'(SRC_RESET) : want_req;
  always_ff @(posedge ref_clk) req_ff <= nxt_req;
  assign src_req = req_ff;
endmodule : ips_src_model

// ---- ips_regs_asserts.sv ----
`timescale 1ns/1ps
module ips_regs_asserts (
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire ips_pkg::ips_src_t src_req,
  input wire logic [15:0]       avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [31:0]       avs_writedata,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic              irq
);
  import ips_pkg::*;
  // sources settled long enough to cover the synchroniser delay
  logic [15:0] src_d_ff;
  logic [2:0]  stab_ff;
  logic [2:0]  nxt_stab;
  logic        ans;
  always_comb nxt_stab = (src_req != src_d_ff) ? 3'h0 : (stab_ff == 3'h7) ? 3'h7 : stab_ff + 3'h1;
  always_ff @(posedge ref_clk) begin
    src_d_ff <= src_req;
    if (rst) stab_ff <= 3'h0;
    else stab_ff <= nxt_stab;
  end
  assign ans = avs_read && !avs_waitrequest;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_answer_next: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_no_spurious: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  chk_reset_quiet: assert property ($fell(rst) |-> avs_waitrequest && !irq && avs_readdata == 32'h0)
    else $error("outputs not quiet after reset");
  chk_low_zero: assert property (ans && avs_address == PENDING_FLAGS_LOW_OFS |->
    avs_readdata[1:0] == 2'h0 && avs_readdata[31:8] == 24'h0) else $error("low spare bits set");
  chk_high_zero: assert property (ans && avs_address == PENDING_FLAGS_HIGH_OFS |->
    avs_readdata[31:2] == 30'h0) else $error("high spare bits set");
  chk_low_map: assert property (ans && stab_ff == 3'h7 && avs_address == PENDING_FLAGS_LOW_OFS |->
    avs_readdata[7:2] == src_req[5:0]) else $error("low flags wrong");
  chk_mid_map: assert property (ans && stab_ff == 3'h7 && avs_address == PENDING_FLAGS_MID_OFS |->
    avs_readdata[7:0] == src_req[13:6]) else $error("mid flags wrong");
  chk_high_map: assert property (ans && stab_ff == 3'h7 && avs_address == PENDING_FLAGS_HIGH_OFS |->
    avs_readdata[1:0] == src_req[15:14]) else $error("high flags wrong");
endmodule : ips_regs_asserts
bind ips_regs ips_regs_asserts chk_i (.ref_clk(ref_clk), .rst(rst), .src_req(src_req),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq));

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import ips_pkg::*;
  logic        ref_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic        avs_waitrequest, irq;
  logic [15:0] avs_address = 16'h0, p, b;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, seed = 32'h1C3A;
  ips_src_t    want_req = '0, src_req;
  int          n_fail = 0, checks = 0;
  always #20 ref_clk = ~ref_clk;
  ips_src_model src_i (.want_req(want_req), .ref_clk(ref_clk), .rst(rst), .src_req(src_req));
  ips_regs dut (.ref_clk(ref_clk), .rst(rst), .src_req(src_req), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  // xorshift source of repeatable stimulus
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // what a pending-flag read should return for request levels v
  function automatic logic [31:0] exp_flags(logic [15:0] a, logic [15:0] v);
    case (a)
      PENDING_FLAGS_LOW_OFS:  return {24'h0, v[5:0], 2'h0};
      PENDING_FLAGS_MID_OFS:  return {24'h0, v[13:6]};
      PENDING_FLAGS_HIGH_OFS: return {30'h0, v[15:14]};
      default:                return 32'h0;
    endcase
  endfunction : exp_flags
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one avalon access; request held until waitrequest is sampled low at a rising edge
  task automatic bus(logic wr, logic [15:0] a, logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic complete_run;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    repeat (6000) @(posedge ref_clk);
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    for (int a = 0; a < 3; a++) begin
      bus(1'b0, PENDING_FLAGS_LOW_OFS + 16'(a), 32'h0);
      chk("reset_flags", 32'h0, rd);
    end
    $display("test reset done");
    // level mirror, with writes in odd rounds that must change nothing
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      p = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h5555 : seed[15:0];
      want_req <= p;
      repeat (10) @(posedge ref_clk);
      for (int a = 0; a < 3; a++) begin
        if (i % 2 == 1) bus(1'b1, PENDING_FLAGS_LOW_OFS + 16'(a), seed);
        bus(1'b0, PENDING_FLAGS_LOW_OFS + 16'(a), 32'h0);
        chk("flags", exp_flags(PENDING_FLAGS_LOW_OFS + 16'(a), p), rd);
      end
    end
    bus(1'b1, 16'hFE10, seed);
    bus(1'b0, 16'hFE10, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test mirror done");
    // sticky status, mask and level interrupt per random source
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      b = 16'h1 << seed[3:0];
      want_req <= '0;
      repeat (8) @(posedge ref_clk);
      bus(1'b1, IRQ_STATUS_OFS, 32'hFFFF);
      bus(1'b1, IRQ_MASK_OFS, 32'h0);
      want_req <= b;
      repeat (8) @(posedge ref_clk);
      bus(1'b0, IRQ_STATUS_OFS, 32'h0);
      chk("status", {16'h0, b}, rd);
      chk("irq_masked", 32'h0, {31'h0, irq});
      bus(1'b1, IRQ_MASK_OFS, {16'h0, b});
      want_req <= '0;
      repeat (8) @(posedge ref_clk);
      chk("irq_set", 32'h1, {31'h0, irq});
      bus(1'b1, IRQ_STATUS_OFS, {16'h0, b});
      repeat (3) @(posedge ref_clk);
      chk("irq_clear", 32'h0, {31'h0, irq});
    end
    $display("test irq done");
    complete_run();
  end
endmodule : tb_top
